// file: usf_params.svh
/*
 * Constants of the asynchronous serial status block: register offsets,
 * status bit positions, reset values and widths.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH

// Register offsets on the 12-bit register port
`define USF_ADDR_W        12
`define USF_ADDR_STATUS   12'hf98
`define USF_ADDR_DATA     12'hf9a
`define USF_ADDR_INT_STAT 12'hf9c
`define USF_ADDR_INT_MASK 12'hf9d

// Register data width
`define USF_REG_W 8

// Status bit positions, shared by the interrupt status and mask registers
`define USF_BIT_PARITY   7
`define USF_BIT_FRAMING  6
`define USF_BIT_OVERRUN  5
`define USF_BIT_RX_FULL  4
`define USF_BIT_TX_DONE  3
`define USF_BIT_TX_EMPTY 2
`define USF_FLAG_LO      2
`define USF_FLAG_HI      7
`define USF_NFLAGS       6

// Reset values
`define USF_STATUS_RST 8'h0c
`define USF_RXBUF_RST  8'h00
`define USF_TXBUF_RST  8'h00
`define USF_RD_IDLE    8'h00
`define USF_INT_RST    6'h00

// Frame data width limits the logic can serve
`define USF_DATA_W_MIN 5
`define USF_DATA_W_MAX 8

`endif

// file: usf_pkg.sv
/*
 * Types of the asynchronous serial status block.
 * Assumes usf_params.svh is on the include path.
 */
`include "usf_params.svh"

package usf_pkg;

	// Transmit shifter ownership as seen by the status logic
	typedef enum logic {
		usf_tx_idle,
		usf_tx_send
	} usf_tx_e;

	typedef logic [`USF_REG_W-1:0] usf_reg_t;
	typedef logic [`USF_NFLAGS-1:0] usf_flags_t;

endpackage : usf_pkg

// file: usf_irq.sv
/*
 * Sticky interrupt status with write-one-to-clear, a mask register of the
 * same layout and one registered level interrupt output.
 * Assumes one clock, synchronous active-low reset and a common clock enable.
 */
`timescale 1ns/1ps
`include "usf_params.svh"

module usf_irq
	import usf_pkg::*;
#(
	parameter int N = `USF_NFLAGS
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	input  wire logic [N-1:0] event_set,
	input  wire logic         stat_wr,
	input  wire logic         mask_wr,
	input  wire logic [N-1:0] wdata,
	output logic      [N-1:0] stat_r,
	output logic      [N-1:0] mask_r,
	output logic              irq_r
);

	logic [N-1:0] stat_nxt;
	logic         irq_nxt;

	generate
		if (N < 1) begin : g_bad_n
			$error("usf_irq needs at least one event");
		end
	endgenerate

	// Per bit: an event in the clearing cycle wins over the clear
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			assign stat_nxt[i] = event_set[i] | (stat_r[i] & ~(stat_wr & wdata[i]));
		end
	endgenerate

	assign irq_nxt = |(stat_nxt & (mask_wr ? wdata : mask_r));

	// Status, mask and output level
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stat_r <= '0;
			mask_r <= '0;
			irq_r  <= 1'b0;
		end else if (ce) begin
			stat_r <= stat_nxt;
			if (mask_wr) begin
				mask_r <= wdata;
			end
			irq_r <= irq_nxt;
		end
	end

endmodule : usf_irq

// file: usf_status.sv
/*
 * Status flag logic of an asynchronous serial transceiver: receive buffer,
 * framing/parity/overrun flags, transmit buffer empty and transmit end,
 * the status-read-then-access clear sequence and the interrupt registers.
 * Assumes a separate bit sampler that hands over finished frames and a
 * separate transmit shifter that takes a byte on a load pulse.
 */
// The strobed register port and the register addresses were decided locally.
//
// Contract
// - Stop bit sampled low sets the framing error flag.
// - Framing error clears only on buffer read after a status read.
// - Frame finishing while buffer still unread sets the overrun flag.
// - On overrun the new byte is dropped, buffer keeps old contents.
// - Overrun clears on buffer read following a status read.
// - While overrun is set no further frame is accepted or stored.
// - Loading a received byte sets the receive buffer full flag.
// - Buffer full clears on buffer read after a status read.
// - Overrun raised between status read and buffer read survives that read.
// - Buffer empty sets when the byte moves into the shifter.
// - Buffer empty clears on transmit write after a status read.
// - Frame shifted out with no pending byte sets transmit end.
// - Transmit end clears once a new transmission actually starts.
// - Parity mismatch sets parity error, cleared like framing error.
// - Setting receive buffer full also pulses the receive interrupt request.
// - Transmission start sets buffer empty and pulses transmit interrupt.
`timescale 1ns/1ps
`include "usf_params.svh"

module usf_status
	import usf_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	input  wire logic                   ce,
	// Register port
	input  wire logic [`USF_ADDR_W-1:0] bus_addr,
	input  wire logic [`USF_REG_W-1:0]  bus_wdata,
	input  wire logic                   bus_wr,
	input  wire logic                   bus_rd,
	output logic      [`USF_REG_W-1:0]  bus_rdata,
	// Frame format, from the control register
	input  wire logic                   parity_en,
	input  wire logic                   parity_odd,
	// To and from the receive bit sampler
	input  wire logic                   rx_frame_done,
	input  wire logic [DATA_W-1:0]      rx_frame_data,
	input  wire logic                   rx_stop_bit,
	input  wire logic                   rx_parity_bit,
	output logic                        rx_enable,
	// To and from the transmit shifter
	output logic                        tx_load,
	output logic      [`USF_REG_W-1:0]  tx_load_data,
	input  wire logic                   tx_frame_done,
	// Interrupts
	output logic                        rx_interrupt_request,
	output logic                        tx_interrupt_request,
	output logic                        irq
);

	generate
		if (DATA_W < `USF_DATA_W_MIN || DATA_W > `USF_DATA_W_MAX) begin : g_bad_w
			$error("usf_status: DATA_W must lie between 5 and 8");
		end
	endgenerate

	// Address match, used by every strobe decode
	// Exact match only; no register shows up at an alias address
	function automatic logic hit(
		input logic [`USF_ADDR_W-1:0] addr,
		input logic [`USF_ADDR_W-1:0] target
	);
		hit = (addr == target);
	endfunction : hit

	// Reset image of the status register; each flag takes its own bit
	localparam usf_reg_t STATUS_RST = `USF_STATUS_RST;

	// Flag registers
	logic parity_error_flag_r;
	logic framing_error_flag_r;
	logic overrun_flag_r;
	logic rx_buffer_full_flag_r;
	logic tx_done_flag_r;
	logic tx_buffer_empty_flag_r;
	logic parity_error_flag_nxt;
	logic framing_error_flag_nxt;
	logic overrun_flag_nxt;
	logic rx_buffer_full_flag_nxt;
	logic tx_done_flag_nxt;
	logic tx_buffer_empty_flag_nxt;

	// Clear-sequence state
	logic armed_r;
	logic armed_nxt;
	logic overrun_seen_r;
	logic overrun_seen_nxt;

	// Data buffers and transmit ownership
	usf_reg_t rx_data_buffer_r;
	usf_reg_t tx_data_buffer_r;
	usf_tx_e  tx_state_r;
	usf_tx_e  tx_state_nxt;

	// Output flops
	usf_reg_t bus_rdata_r;
	usf_reg_t bus_rdata_nxt;
	logic     tx_load_r;
	usf_reg_t tx_load_data_r;
	logic     rx_irq_req_r;
	logic     tx_irq_req_r;
	logic     rx_enable_r;

	// Interrupt block
	usf_flags_t int_stat;
	usf_flags_t int_mask;
	usf_flags_t int_event;
	logic       irq_r;

	// Strobe decode, all frozen by the clock enable
	// Interrupt register reads are qualified at the mux; they clear nothing
	wire status_rd = ce & bus_rd & hit(bus_addr, `USF_ADDR_STATUS);
	wire rxbuf_rd  = ce & bus_rd & hit(bus_addr, `USF_ADDR_DATA);
	wire txbuf_wr  = ce & bus_wr & hit(bus_addr, `USF_ADDR_DATA);
	wire istat_wr  = ce & bus_wr & hit(bus_addr, `USF_ADDR_INT_STAT);
	wire imask_wr  = ce & bus_wr & hit(bus_addr, `USF_ADDR_INT_MASK);
	wire istat_rd  = hit(bus_addr, `USF_ADDR_INT_STAT);
	wire imask_rd  = hit(bus_addr, `USF_ADDR_INT_MASK);

	// Arming: each status read arms, the next data access consumes it
	assign armed_nxt = status_rd ? 1'b1 :
		(rxbuf_rd | txbuf_wr) ? 1'b0 : armed_r;

	// Clear strobes exist only on an armed access
	// An unarmed data read still returns the byte but leaves every flag
	// A write while a byte still waits is lost; software must poll empty
	wire rx_clear = rxbuf_rd & armed_r;
	wire tx_write = txbuf_wr & armed_r & tx_buffer_empty_flag_r;

	// Overrun level as software last saw it in the status register.
	// A later overrun is not cleared by the pending buffer read.
	assign overrun_seen_nxt = status_rd ? overrun_flag_r :
		rxbuf_rd ? 1'b0 : overrun_seen_r;

	// Receive acceptance: nothing is taken while overrun stands
	// Trade-off: a frame arriving during overrun is lost without trace
	wire rx_accept   = ce & rx_frame_done & ~overrun_flag_r;
	// A read that empties the buffer this cycle frees it for the new frame
	wire rx_occupied = rx_buffer_full_flag_r & ~rx_clear;
	wire rx_load     = rx_accept & ~rx_occupied;
	wire rx_overrun  = rx_accept & rx_occupied;

	// Parity expected from the data bits, even or odd
	// Judged only on loaded frames; a dropped frame marks overrun only
	wire parity_calc = (^rx_frame_data) ^ parity_odd;
	wire parity_bad  = parity_en & (parity_calc != rx_parity_bit);
	wire framing_bad = ~rx_stop_bit;

	// Receive flags: a set in the clearing cycle wins
	assign framing_error_flag_nxt =
		(rx_load & framing_bad) ? 1'b1 :
		rx_clear ? 1'b0 : framing_error_flag_r;

	assign parity_error_flag_nxt =
		(rx_load & parity_bad) ? 1'b1 :
		rx_clear ? 1'b0 : parity_error_flag_r;

	assign rx_buffer_full_flag_nxt =
		rx_load ? 1'b1 :
		rx_clear ? 1'b0 : rx_buffer_full_flag_r;

	assign overrun_flag_nxt =
		rx_overrun ? 1'b1 :
		(rx_clear & overrun_seen_r) ? 1'b0 :
		overrun_flag_r;

	// Transmit: the shifter takes a byte only when idle and one is pending
	wire tx_start = ce & (tx_state_r == usf_tx_idle) & ~tx_buffer_empty_flag_r;
	wire tx_end   = ce & tx_frame_done & (tx_state_r == usf_tx_send);

	// Start and write never coincide: one needs empty, the other full
	assign tx_buffer_empty_flag_nxt =
		tx_start ? 1'b1 :
		tx_write ? 1'b0 : tx_buffer_empty_flag_r;

	// End only counts if no byte waits; a waiting byte starts next cycle
	// A shifter end with nothing loaded is ignored by the ownership state
	assign tx_done_flag_nxt =
		tx_start ? 1'b0 :
		(tx_end & tx_buffer_empty_flag_r) ? 1'b1 :
		tx_done_flag_r;

	// Shifter ownership
	always_comb begin
		tx_state_nxt = tx_state_r;
		case (tx_state_r)
			usf_tx_idle: begin
				if (tx_start) begin
					tx_state_nxt = usf_tx_send;
				end
			end
			usf_tx_send: begin
				if (tx_end) begin
					tx_state_nxt = usf_tx_idle;
				end
			end
			default: begin
				tx_state_nxt = usf_tx_idle;
			end
		endcase
	end

	// Interrupt events on the same bit layout as the status register
	// Order must match the status word, or software sees shifted bits
	assign int_event[`USF_BIT_PARITY-`USF_FLAG_LO]   = rx_load & parity_bad;
	assign int_event[`USF_BIT_FRAMING-`USF_FLAG_LO]  = rx_load & framing_bad;
	assign int_event[`USF_BIT_OVERRUN-`USF_FLAG_LO]  = rx_overrun;
	assign int_event[`USF_BIT_RX_FULL-`USF_FLAG_LO]  = rx_load;
	assign int_event[`USF_BIT_TX_DONE-`USF_FLAG_LO]  = tx_end & tx_buffer_empty_flag_r;
	assign int_event[`USF_BIT_TX_EMPTY-`USF_FLAG_LO] = tx_start;

	// Status word as software sees it; low bits read zero
	wire [`USF_REG_W-1:0] status_word = {
		parity_error_flag_r,
		framing_error_flag_r,
		overrun_flag_r,
		rx_buffer_full_flag_r,
		tx_done_flag_r,
		tx_buffer_empty_flag_r,
		2'b00
	};

	// Read mux; the transmit buffer is write only and not visible
	// Any unmatched read returns the idle value, never stale data
	always_comb begin
		bus_rdata_nxt = `USF_RD_IDLE;
		if (status_rd) begin
			bus_rdata_nxt = status_word;
		end else if (rxbuf_rd) begin
			bus_rdata_nxt = rx_data_buffer_r;
		end else if (ce & bus_rd & istat_rd) begin
			bus_rdata_nxt = {int_stat, 2'b00};
		end else if (ce & bus_rd & imask_rd) begin
			bus_rdata_nxt = {int_mask, 2'b00};
		end
	end

	// Flag registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			parity_error_flag_r    <= STATUS_RST[`USF_BIT_PARITY];
			framing_error_flag_r   <= STATUS_RST[`USF_BIT_FRAMING];
			overrun_flag_r         <= STATUS_RST[`USF_BIT_OVERRUN];
			rx_buffer_full_flag_r  <= STATUS_RST[`USF_BIT_RX_FULL];
			tx_done_flag_r         <= STATUS_RST[`USF_BIT_TX_DONE];
			tx_buffer_empty_flag_r <= STATUS_RST[`USF_BIT_TX_EMPTY];
		end else if (ce) begin
			parity_error_flag_r    <= parity_error_flag_nxt;
			framing_error_flag_r   <= framing_error_flag_nxt;
			overrun_flag_r         <= overrun_flag_nxt;
			rx_buffer_full_flag_r  <= rx_buffer_full_flag_nxt;
			tx_done_flag_r         <= tx_done_flag_nxt;
			tx_buffer_empty_flag_r <= tx_buffer_empty_flag_nxt;
		end
	end

	// Clear-sequence state and shifter ownership
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			armed_r        <= 1'b0;
			overrun_seen_r <= 1'b0;
			tx_state_r     <= usf_tx_idle;
		end else if (ce) begin
			armed_r        <= armed_nxt;
			overrun_seen_r <= overrun_seen_nxt;
			tx_state_r     <= tx_state_nxt;
		end
	end

	// Receive buffer: an overrun frame never reaches it
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rx_data_buffer_r <= `USF_RXBUF_RST;
		end else if (rx_load) begin
			rx_data_buffer_r <= usf_reg_t'(rx_frame_data);
		end
	end

	// Transmit buffer: an unarmed write is dropped, the byte never lands
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tx_data_buffer_r <= `USF_TXBUF_RST;
		end else if (tx_write) begin
			tx_data_buffer_r <= bus_wdata;
		end
	end

	// Registered outputs: pulses last one enabled cycle
	// Enable follows the next overrun value so the sampler stops on that edge
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bus_rdata_r    <= `USF_RD_IDLE;
			tx_load_r      <= 1'b0;
			tx_load_data_r <= `USF_TXBUF_RST;
			rx_irq_req_r   <= 1'b0;
			tx_irq_req_r   <= 1'b0;
			rx_enable_r    <= ~STATUS_RST[`USF_BIT_OVERRUN];
		end else if (ce) begin
			bus_rdata_r  <= bus_rdata_nxt;
			tx_load_r    <= tx_start;
			rx_irq_req_r <= rx_load;
			tx_irq_req_r <= tx_start;
			rx_enable_r  <= ~overrun_flag_nxt;
			if (tx_start) begin
				tx_load_data_r <= tx_data_buffer_r;
			end
		end
	end

	// Sticky interrupt status, mask and level output
	// Only bits 7:2 are stored; the two low bits always read zero
	usf_irq #(
		.N (`USF_NFLAGS)
	) u_irq (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.ce        (ce),
		.event_set (int_event),
		.stat_wr   (istat_wr),
		.mask_wr   (imask_wr),
		.wdata     (bus_wdata[`USF_FLAG_HI:`USF_FLAG_LO]),
		.stat_r    (int_stat),
		.mask_r    (int_mask),
		.irq_r     (irq_r)
	);

	assign bus_rdata            = bus_rdata_r;
	assign tx_load              = tx_load_r;
	assign tx_load_data         = tx_load_data_r;
	assign rx_interrupt_request = rx_irq_req_r;
	assign tx_interrupt_request = tx_irq_req_r;
	assign rx_enable            = rx_enable_r;
	assign irq                  = irq_r;

endmodule : usf_status

// file: usf_status_chk.sv
/* Checker of the serial status block: receive and transmit pulses, receiver gating.
   Assumes it is bound to usf_status, one clock; ce drops only while no pulse stands. */
`timescale 1ns/1ps

module usf_status_chk (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic [11:0] bus_addr,
	input wire logic        bus_rd,
	input wire logic        rx_frame_done,
	input wire logic        rx_enable,
	input wire logic        tx_load,
	input wire logic [7:0]  tx_load_data,
	input wire logic        rx_interrupt_request,
	input wire logic        tx_interrupt_request
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// A receive request needs an accepted frame one edge earlier
	a_rx_req_src: assert property (
		rx_interrupt_request |-> $past(rx_frame_done && rx_enable && ce))
		else $error("receive request without an accepted frame");
	a_rx_req_one: assert property (
		rx_interrupt_request |=> !rx_interrupt_request)
		else $error("receive request longer than one cycle");
	// Frames offered while the receiver is shut must leave no trace
	a_rx_gate: assert property (
		rx_frame_done && !rx_enable |=> !rx_interrupt_request)
		else $error("frame taken while receiver shut");
	a_ovr_stop: assert property (
		$fell(rx_enable) |-> $past(rx_frame_done))
		else $error("receiver shut without a frame");
	// Registered enable may lag the clearing read by one edge
	a_ovr_resume: assert property (
		$rose(rx_enable) |-> $past(bus_rd && bus_addr == 12'hf9a)
			|| $past(bus_rd && bus_addr == 12'hf9a, 2))
		else $error("receiver reopened without a buffer read");
	a_tx_pair: assert property (
		tx_load == tx_interrupt_request)
		else $error("transmit request apart from load");
	a_tx_one: assert property (
		tx_load |=> !tx_load)
		else $error("load longer than one cycle");
	a_tx_hold: assert property (
		!tx_load |-> $stable(tx_load_data))
		else $error("shifter byte moved without a load");
endmodule : usf_status_chk

bind usf_status usf_status_chk i_chk (
	.core_clk(core_clk), .nrst(nrst), .ce(ce), .bus_addr(bus_addr), .bus_rd(bus_rd),
	.rx_frame_done(rx_frame_done), .rx_enable(rx_enable), .tx_load(tx_load),
	.tx_load_data(tx_load_data), .rx_interrupt_request(rx_interrupt_request),
	.tx_interrupt_request(tx_interrupt_request));

// file: usf_peer.sv
/* Far side model: bit sampler handing over frames and a shifter taking bytes.
   Assumes the bench commands frames by a one-cycle send pulse. */
`timescale 1ns/1ps

module usf_peer #(
	parameter int TX_CYC = 20
) (
	input wire logic       core_clk,
	input wire logic       send,
	input wire logic       force_in,
	input wire logic       stop_in,
	input wire logic       bad_par,
	input wire logic       parity_odd,
	input wire logic [7:0] data_in,
	input wire logic       rx_enable,
	input wire logic       tx_load,
	input wire logic [7:0] tx_load_data,
	output logic           rx_frame_done,
	output logic [7:0]     rx_frame_data,
	output logic           rx_stop_bit,
	output logic           rx_parity_bit,
	output logic           tx_frame_done,
	output logic [7:0]     load_count
);
	int cnt;

	initial begin
		{rx_frame_done, rx_frame_data, rx_stop_bit, rx_parity_bit} = '0;
		tx_frame_done = 1'h0;
		load_count = 8'h00;
		cnt = 0;
	end

	// Outside a frame the lines toggle, so stale values never pass as data
	always @(posedge core_clk) begin
		rx_frame_done <= send && (rx_enable || force_in); // force_in breaks the enable
		rx_frame_data <= send ? data_in : ~rx_frame_data;
		rx_stop_bit <= send ? stop_in : ~rx_stop_bit;
		rx_parity_bit <= send ? (^data_in ^ parity_odd ^ bad_par) : ~rx_parity_bit;
		tx_frame_done <= (cnt == 1);
		if (tx_load) begin
			cnt <= TX_CYC;
			load_count <= load_count + 8'h01;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : usf_peer

// file: testbench.sv
/* Self-checking bench of the serial status block with its far side model.
   Assumes usf_status with DATA_W 8; ce is high except in one freeze test. */
`timescale 1ns/1ps

module testbench;
	import usf_pkg::*;
	typedef struct {logic [7:0] d; logic stop; logic bad; logic odd; logic [7:0] st;} usf_row_s;

	logic        core_clk, nrst, ce, bus_wr, bus_rd, parity_en, parity_odd, irq;
	logic [11:0] bus_addr;
	logic [7:0]  bus_wdata, bus_rdata, rx_frame_data, tx_load_data, data_in, load_count;
	logic        rx_frame_done, rx_stop_bit, rx_parity_bit, rx_enable, tx_load;
	logic        tx_frame_done, rx_interrupt_request, tx_interrupt_request;
	logic        send, force_in, stop_in, bad_par;
	int          failures, cmp_count, n;
	// Frames with every stop and parity outcome, both parity senses
	usf_row_s rows [4] = '{'{8'ha5, 1'h1, 1'h0, 1'h0, 8'h1c}, '{8'h3c, 1'h0, 1'h0, 1'h1, 8'h5c},
		'{8'h81, 1'h1, 1'h1, 1'h0, 8'h9c}, '{8'h7e, 1'h0, 1'h1, 1'h1, 8'hdc}};

	usf_status i_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.parity_en(parity_en), .parity_odd(parity_odd), .rx_frame_done(rx_frame_done),
		.rx_frame_data(rx_frame_data), .rx_stop_bit(rx_stop_bit),
		.rx_parity_bit(rx_parity_bit), .rx_enable(rx_enable), .tx_load(tx_load),
		.tx_load_data(tx_load_data), .tx_frame_done(tx_frame_done),
		.rx_interrupt_request(rx_interrupt_request),
		.tx_interrupt_request(tx_interrupt_request), .irq(irq));

	usf_peer i_peer (.core_clk(core_clk), .send(send), .force_in(force_in),
		.stop_in(stop_in), .bad_par(bad_par), .parity_odd(parity_odd), .data_in(data_in),
		.rx_enable(rx_enable), .tx_load(tx_load), .tx_load_data(tx_load_data),
		.rx_frame_done(rx_frame_done), .rx_frame_data(rx_frame_data),
		.rx_stop_bit(rx_stop_bit), .rx_parity_bit(rx_parity_bit),
		.tx_frame_done(tx_frame_done), .load_count(load_count));

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Read strobe for one cycle, data taken in the cycle after
	task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_rd <= 1'h1;
		bus_addr <= a;
		@(posedge core_clk);
		bus_rd <= 1'h0;
		#1;
		chk("bus_rdata", bus_rdata, exp);
	endtask : rdc

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_wr <= 1'h1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge core_clk);
		bus_wr <= 1'h0;
	endtask : wr

	task automatic frm(input logic [7:0] d, input logic s, b, o, f);
		@(posedge core_clk);
		{send, data_in, stop_in, bad_par, parity_odd, force_in} <= {1'h1, d, s, b, o, f};
		@(posedge core_clk);
		send <= 1'h0;
	endtask : frm

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done

	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end

	// Whole run is under two hundred cycles
	initial begin
		repeat (3000) @(posedge core_clk);
		failures++;
		end_sim;
	end

	initial begin
		{nrst, bus_wr, bus_rd, send, force_in, stop_in, bad_par, parity_odd} = '0;
		{ce, parity_en, bus_addr, bus_wdata, data_in} = {1'h1, 1'h1, 28'h0};
		failures = 0;
		cmp_count = 0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'h1;
		rdc(12'hf98, 8'h0c);
		rdc(12'h123, 8'h00);
		done("reset");
		foreach (rows[i]) begin
			frm(rows[i].d, rows[i].stop, rows[i].bad, rows[i].odd, 1'h0);
			rdc(12'hf98, rows[i].st);
			rdc(12'hf9a, rows[i].d);
			rdc(12'hf98, 8'h0c);
		end
		done("rows");
		// Second frame lands between the status read and the buffer read
		frm(8'h11, 1'h1, 1'h0, 1'h0, 1'h0);
		rdc(12'hf98, 8'h1c);
		frm(8'h22, 1'h1, 1'h0, 1'h0, 1'h0);
		rdc(12'hf9a, 8'h11);
		rdc(12'hf98, 8'h2c);
		chk("rx_enable", {7'h0, rx_enable}, 8'h00);
		frm(8'h33, 1'h0, 1'h1, 1'h0, 1'h1);
		rdc(12'hf9a, 8'h11);
		rdc(12'hf98, 8'h0c);
		chk("rx_enable", {7'h0, rx_enable}, 8'h01);
		done("overrun");
		// A buffer read consumes the arm, so the byte that follows is lost
		rdc(12'hf9a, 8'h11);
		wr(12'hf9a, 8'h5a);
		repeat (4) @(posedge core_clk);
		chk("load_count", load_count, 8'h00);
		rdc(12'hf98, 8'h0c);
		wr(12'hf9a, 8'hc3);
		for (n = 0; n < 8 && tx_load !== 1'h1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk("tx_load", {7'h0, tx_load}, 8'h01);
		chk("tx_load_data", tx_load_data, 8'hc3);
		rdc(12'hf98, 8'h04);
		repeat (30) @(posedge core_clk);
		rdc(12'hf98, 8'h0c);
		chk("load_count", load_count, 8'h01);
		done("transmit");
		wr(12'hf9c, 8'hfc);
		wr(12'hf9d, 8'h10);
		rdc(12'hf9c, 8'h00);
		frm(8'h5a, 1'h1, 1'h0, 1'h0, 1'h0);
		rdc(12'hf9c, 8'h10);
		chk("irq", {7'h0, irq}, 8'h01);
		wr(12'hf9d, 8'h00);
		@(posedge core_clk);
		#1;
		chk("irq", {7'h0, irq}, 8'h00);
		wr(12'hf9c, 8'h10);
		rdc(12'hf9c, 8'h00);
		done("interrupt");
		// Mid-run reset with overrun standing and an unmasked request
		wr(12'hf9d, 8'h20);
		frm(8'h66, 1'h1, 1'h0, 1'h0, 1'h0);
		rdc(12'hf98, 8'h3c);
		chk("irq", {7'h0, irq}, 8'h01);
		@(posedge core_clk);
		nrst <= 1'h0;
		repeat (4) @(posedge core_clk);
		nrst <= 1'h1;
		#1;
		chk("irq", {7'h0, irq}, 8'h00);
		chk("rx_enable", {7'h0, rx_enable}, 8'h01);
		rdc(12'hf98, 8'h0c);
		rdc(12'hf9a, 8'h00);
		rdc(12'hf9d, 8'h00);
		done("reset again");
		// Frozen clock enable: a frame offered then leaves no trace
		@(posedge core_clk);
		ce <= 1'h0;
		frm(8'h44, 1'h1, 1'h0, 1'h0, 1'h0);
		repeat (2) @(posedge core_clk);
		ce <= 1'h1;
		rdc(12'hf98, 8'h0c);
		// Parity check off: a wrong parity bit raises no error
		@(posedge core_clk);
		parity_en <= 1'h0;
		frm(8'h81, 1'h1, 1'h1, 1'h0, 1'h0);
		rdc(12'hf98, 8'h1c);
		done("enable and parity");
		end_sim;
	end
endmodule : testbench
